// >>> logic/link_error_defs.svh
// Purpose: offsets, field positions and reset values for the link error block
// Assumes: byte addresses on the register port
// Notes:   definitions only
`ifndef LINK_ERROR_DEFS_SVH
`define LINK_ERROR_DEFS_SVH

`define OFS_PHY_STATE_MIRROR   8'hB0
`define OFS_PHY_TEST_CLK_CLR   8'hB4
`define OFS_PHY_TEST_DATA_SEL  8'hB8
`define OFS_LINK_ERR_STATUS_A  8'hBC
`define OFS_LINK_ERR_STATUS_B  8'hC0
`define OFS_LINK_ERR_MASK_A    8'hC4

`define TEST_CLK_BIT           1
`define TEST_CLR_BIT           0
`define TEST_CLR_RESET         1'h1
`define TEST_SEL_BIT           16
`define TEST_DOUT_LSB          8
`define STATUS_A_BITS          21
`define STATUS_B_BITS          13
`define LANE_ERR_LSB           16

`endif

// >>> logic/link_error_pkg.sv
// Purpose: types shared by the link error block
// Assumes: nothing
// Notes:   structs only; constants live in link_error_defs.svh
`default_nettype none
package link_error_pkg;

    // live PHY protocol-interface state
    typedef struct packed {
        logic lane0_sleep_active_n;
        logic lane0_idle_state;
        logic clk_sleep_active_n;
        logic clk_idle_state;
        logic bus_direction;
        logic pll_locked;
    } phy_state_t;

    // lane 0 error strobes, bit order matches status a bits 20..16
    typedef struct packed {
        logic lp1_contention_signal;
        logic lp0_contention_signal;
        logic control_fault_signal;
        logic escape_sync_fault_signal;
        logic escape_entry_fault_signal;
    } lane_err_t;

    // controller error strobes, bit order matches status b bits 12..0
    typedef struct packed {
        logic read_pld_overflow;
        logic command_set_pld_underflow;
        logic write_pld_underflow;
        logic write_pld_full_write;
        logic command_full_write;
        logic pixel_pld_overflow;
        logic missing_end_packet;
        logic packet_size_fault;
        logic checksum_fault;
        logic ecc_multi_fault;
        logic ecc_single_fault;
        logic lowpower_rx_timeout;
        logic highspeed_tx_timeout;
    } ctrl_err_t;

    // test interface drive towards the PHY
    typedef struct packed {
        logic       test_clear;
        logic       test_clock;
        logic       test_addr_sel;
        logic [7:0] test_din;
    } phy_test_t;

    // register state of the block; the synchroniser flops are kept outside it
    typedef struct packed {
        logic        test_clear_r;
        logic        test_clock_r;
        logic        test_sel_r;
        logic [7:0]  test_din_r;
        logic [20:0] status_a_r;
        logic [12:0] status_b_r;
        logic [20:0] mask_a_r;
        logic [31:0] rdata_r;
    } state_t;

endpackage
`default_nettype wire

// >>> logic/link_error_status.sv
// Purpose: PHY state mirror, PHY test interface drive and latched link error status
// Assumes: phy and error strobes come from the PHY domain; register port is on sys_clk
// Notes:   reads of the error status registers clear them
//          irq is a level; status b has no mask in this block
//          PHY inputs pass two flops before any logic reads them
//          lane errors are edge detected so a held level sets once
`include "link_error_defs.svh"
`default_nettype none

module link_error_status (
    input  wire logic                     sys_clk,
    input  wire logic                     rst_n,
    input  wire logic                     clk_en,
    // register port
    input  wire logic                     reg_sel,
    input  wire logic                     reg_write,
    input  wire logic [7:0]               reg_addr,
    input  wire logic [31:0]              reg_wdata,
    output logic      [31:0]              reg_rdata,
    // PHY side
    input  wire link_error_pkg::phy_state_t phy_state,
    input  wire logic [7:0]               phy_test_dout,
    output link_error_pkg::phy_test_t     phy_test,
    // error event sources
    input  wire link_error_pkg::lane_err_t lane_err,
    input  wire logic                     ack_report_valid,
    input  wire logic [15:0]              ack_report_bits,
    input  wire link_error_pkg::ctrl_err_t ctrl_err,
    // write strobes of the generic FIFOs, for the full-write errors
    input  wire logic                     gen_pld_write,
    input  wire logic                     gen_pld_full,
    input  wire logic                     gen_cmd_write,
    input  wire logic                     gen_cmd_full,
    output logic                          gen_pld_accept,
    output logic                          gen_cmd_accept,
    output logic                          irq
);

    ////////////////////////////////////////////////////////////////////////
    // input synchronisers for the PHY-domain signals
    logic [5:0]  phy_meta_r;
    logic [5:0]  phy_sync_r;
    logic [7:0]  dout_meta_r;
    logic [7:0]  dout_sync_r;
    logic [4:0]  lane_meta_r;
    logic [4:0]  lane_sync_r;
    logic [4:0]  lane_prev_r;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            phy_meta_r  <= 6'h00;
            phy_sync_r  <= 6'h00;
        end else if (clk_en) begin
            phy_meta_r  <= phy_state;
            phy_sync_r  <= phy_meta_r;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            dout_meta_r <= 8'h00;
            dout_sync_r <= 8'h00;
        end else if (clk_en) begin
            dout_meta_r <= phy_test_dout;
            dout_sync_r <= dout_meta_r;
        end
    end

    // lane error synchroniser and edge history
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            lane_meta_r <= 5'h00;
            lane_sync_r <= 5'h00;
            lane_prev_r <= 5'h00;
        end else if (clk_en) begin
            lane_meta_r <= lane_err;
            lane_sync_r <= lane_meta_r;
            lane_prev_r <= lane_sync_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // helpers
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
        hit = (addr == ofs);
    endfunction

    // latched flags: set wins over a read-clear in the same cycle
    function automatic logic [20:0] latch(input logic [20:0] cur,
                                          input logic [20:0] ev,
                                          input logic        clr);
        latch = (clr ? 21'h00_0000 : cur) | ev;
    endfunction

    // status b counterpart, no padding needed
    function automatic logic [12:0] latch_b(input logic [12:0] cur,
                                            input logic [12:0] ev,
                                            input logic        clr);
        latch_b = (clr ? 13'h0000 : cur) | ev;
    endfunction

    link_error_pkg::state_t st_r;
    link_error_pkg::state_t st_nxt;

    // synchronised views of the PHY-side inputs
    link_error_pkg::phy_state_t phy_live;
    logic [4:0]  lane_rise;

    // access decode
    logic        rd_en;
    logic        wr_en;
    logic        rd_status_a;
    logic        rd_status_b;
    logic        wr_test_ctrl;
    logic        wr_test_data;
    logic        wr_mask_a;

    // event and flag next values
    logic [20:0] ev_a;
    logic [12:0] ev_b;
    logic [20:0] sa_next;
    logic [12:0] sb_next;
    logic        pld_drop;
    logic        cmd_drop;

    // read-back words, one per register
    logic [31:0] word_mirror;
    logic [31:0] word_test_ctrl;
    logic [31:0] word_test_data;
    logic [31:0] word_status_a;
    logic [31:0] word_status_b;
    logic [31:0] word_mask_a;

    assign rd_en        = reg_sel && !reg_write;
    assign wr_en        = reg_sel && reg_write;
    assign rd_status_a  = rd_en && hit(reg_addr, `OFS_LINK_ERR_STATUS_A);
    assign rd_status_b  = rd_en && hit(reg_addr, `OFS_LINK_ERR_STATUS_B);
    assign wr_test_ctrl = wr_en && hit(reg_addr, `OFS_PHY_TEST_CLK_CLR);
    assign wr_test_data = wr_en && hit(reg_addr, `OFS_PHY_TEST_DATA_SEL);
    assign wr_mask_a    = wr_en && hit(reg_addr, `OFS_LINK_ERR_MASK_A);

    // only the second flop of each synchroniser is read
    assign phy_live  = link_error_pkg::phy_state_t'(phy_sync_r);
    // a held error level sets its flag once, not every cycle
    assign lane_rise = lane_sync_r & ~lane_prev_r;

    assign pld_drop       = gen_pld_write && gen_pld_full;
    assign gen_pld_accept = gen_pld_write && !gen_pld_full;
    assign cmd_drop       = gen_cmd_write && gen_cmd_full;
    assign gen_cmd_accept = gen_cmd_write && !gen_cmd_full;

    ////////////////////////////////////////////////////////////////////////
    // error events of this cycle
    always_comb begin
        ev_a = 21'h00_0000;
        ev_b = 13'h0000;

        // lane 0 PHY errors arrive as levels
        // lp1 contention edge
        ev_a[20] = lane_rise[4];
        ev_a[19] = lane_rise[3];
        ev_a[18] = lane_rise[2];
        ev_a[17] = lane_rise[1];
        ev_a[16] = lane_rise[0];

        // report bits count only with their valid
        if (ack_report_valid) begin
            ev_a[15:0] = ack_report_bits;
        end

        // controller strobes, one status b bit each
        // read payload overflow
        ev_b[12] = ctrl_err.read_pld_overflow;
        ev_b[11] = ctrl_err.command_set_pld_underflow;
        ev_b[10] = ctrl_err.write_pld_underflow;
        ev_b[9]  = ctrl_err.write_pld_full_write | pld_drop;
        ev_b[8]  = ctrl_err.command_full_write | cmd_drop;
        ev_b[7]  = ctrl_err.pixel_pld_overflow;
        ev_b[6]  = ctrl_err.missing_end_packet;
        ev_b[5]  = ctrl_err.packet_size_fault;
        ev_b[4]  = ctrl_err.checksum_fault;
        ev_b[3]  = ctrl_err.ecc_multi_fault;
        ev_b[2]  = ctrl_err.ecc_single_fault;
        ev_b[1]  = ctrl_err.lowpower_rx_timeout;
        ev_b[0]  = ctrl_err.highspeed_tx_timeout;
    end

    ////////////////////////////////////////////////////////////////////////
    // read-back words
    always_comb begin
        word_mirror    = 32'h0000_0000;
        word_test_ctrl = 32'h0000_0000;
        word_test_data = 32'h0000_0000;
        word_status_a  = 32'h0000_0000;
        word_status_b  = 32'h0000_0000;
        word_mask_a    = 32'h0000_0000;
        word_mirror[5] = phy_live.lane0_sleep_active_n;
        word_mirror[4] = phy_live.lane0_idle_state;
        word_mirror[3] = phy_live.clk_sleep_active_n;
        word_mirror[2] = phy_live.clk_idle_state;
        word_mirror[1] = phy_live.bus_direction;
        // PLL lock, zero out of reset
        word_mirror[0] = phy_live.pll_locked;

        // test interface registers
        // test clock read-back
        word_test_ctrl[`TEST_CLK_BIT] = st_r.test_clock_r;
        word_test_ctrl[`TEST_CLR_BIT] = st_r.test_clear_r;
        word_test_data[`TEST_SEL_BIT] = st_r.test_sel_r;
        word_test_data[`TEST_DOUT_LSB +: 8] = dout_sync_r;
        word_test_data[7:0] = st_r.test_din_r;

        // error flag and mask registers
        // status a flags
        word_status_a[`STATUS_A_BITS-1:0] = st_r.status_a_r;
        word_status_b[`STATUS_B_BITS-1:0] = st_r.status_b_r;
        word_mask_a[`STATUS_A_BITS-1:0] = st_r.mask_a_r;
    end

    ////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        st_nxt = st_r;

        sa_next = latch(st_r.status_a_r, ev_a, rd_status_a);
        sb_next = latch_b(st_r.status_b_r, ev_b, rd_status_b);
        st_nxt.status_a_r = sa_next;
        st_nxt.status_b_r = sb_next;

        // register writes
        // test clock and clear
        if (wr_test_ctrl) begin
            st_nxt.test_clock_r = reg_wdata[`TEST_CLK_BIT];
            st_nxt.test_clear_r = reg_wdata[`TEST_CLR_BIT];
        end
        if (wr_test_data) begin
            st_nxt.test_sel_r = reg_wdata[`TEST_SEL_BIT];
            st_nxt.test_din_r = reg_wdata[7:0];
        end
        if (wr_mask_a) begin
            st_nxt.mask_a_r = reg_wdata[`STATUS_A_BITS-1:0];
        end
        // writes to other offsets are ignored

        // zero unless a read is taken
        st_nxt.rdata_r = 32'h0000_0000;
        if (rd_en) begin
            case (reg_addr)
                `OFS_PHY_STATE_MIRROR: begin
                    st_nxt.rdata_r = word_mirror;
                end
                `OFS_PHY_TEST_CLK_CLR: begin
                    st_nxt.rdata_r = word_test_ctrl;
                end
                `OFS_PHY_TEST_DATA_SEL: begin
                    st_nxt.rdata_r = word_test_data;
                end
                `OFS_LINK_ERR_STATUS_A: begin
                    st_nxt.rdata_r = word_status_a;
                end
                `OFS_LINK_ERR_STATUS_B: begin
                    st_nxt.rdata_r = word_status_b;
                end
                `OFS_LINK_ERR_MASK_A: begin
                    st_nxt.rdata_r = word_mask_a;
                end
                default: begin
                    st_nxt.rdata_r = 32'h0000_0000;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r              <= '0;
            st_r.test_clear_r <= `TEST_CLR_RESET;
        end else if (clk_en) begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs
    assign reg_rdata = st_r.rdata_r;

    // test interface drive, straight from the register bits
    // clear, high out of reset
    assign phy_test.test_clear    = st_r.test_clear_r;
    assign phy_test.test_clock    = st_r.test_clock_r;
    assign phy_test.test_addr_sel = st_r.test_sel_r;
    assign phy_test.test_din      = st_r.test_din_r;

    // sources that are set and enabled
    logic [20:0] pend_a;
    logic        pend_b;
    assign pend_a = st_r.status_a_r & st_r.mask_a_r;
    // status b has no mask in this block, so every flag reaches irq
    assign pend_b = |st_r.status_b_r;

    // interrupt from masked status a and unmasked status b, a level that falls once the flags are read
    assign irq = |pend_a || pend_b;

endmodule // link_error_status
`default_nettype wire

// >>> testbench/phy_test_model.sv
// Purpose: PHY macro test port model behind the link error block
// Assumes: test clock is toggled by software through register writes
// Notes:   read-back shows the address byte while the selector is one
`default_nettype none
module phy_test_model (
    input  wire link_error_pkg::phy_test_t phy_test,
    output logic [7:0]                     phy_test_dout
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] data_r;
    logic [7:0] addr_r;
    always @(posedge phy_test.test_clock or posedge phy_test.test_clear) begin
        if (phy_test.test_clear) data_r <= 8'h00;
        else if (!phy_test.test_addr_sel) data_r <= phy_test.test_din;
    end
    always @(negedge phy_test.test_clock or posedge phy_test.test_clear) begin
        if (phy_test.test_clear) addr_r <= 8'h00;
        else if (phy_test.test_addr_sel) addr_r <= phy_test.test_din;
    end
    assign phy_test_dout = phy_test.test_addr_sel ? addr_r : data_r;
endmodule // phy_test_model
`default_nettype wire

// >>> testbench/link_error_chk.sv
// Purpose: port-level checks of the link error block
// Assumes: single clock domain
// Notes:   status b has no mask here, so any event raises irq
`include "link_error_defs.svh"
`default_nettype none
module link_error_chk (
    input wire logic                      sys_clk,
    input wire logic                      rst_n,
    input wire logic                      clk_en,
    input wire logic                      reg_sel,
    input wire logic                      reg_write,
    input wire logic [7:0]                reg_addr,
    input wire logic [31:0]               reg_wdata,
    input wire logic [31:0]               reg_rdata,
    input wire link_error_pkg::phy_test_t phy_test,
    input wire link_error_pkg::ctrl_err_t ctrl_err,
    input wire logic                      ack_report_valid,
    input wire logic [15:0]               ack_report_bits,
    input wire logic                      gen_pld_write,
    input wire logic                      gen_pld_full,
    input wire logic                      gen_pld_accept,
    input wire logic                      irq
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    sequence wr_to(logic [7:0] a); clk_en && reg_sel && reg_write && reg_addr == a; endsequence
    sequence rd_of(logic [7:0] a); clk_en && reg_sel && !reg_write && reg_addr == a; endsequence
    test_clk_a: assert property (wr_to(`OFS_PHY_TEST_CLK_CLR) |=>
        phy_test.test_clock == $past(reg_wdata[1]) && phy_test.test_clear == $past(reg_wdata[0]))
        else $error("test clock or clear not taken from write");
    test_din_a: assert property (wr_to(`OFS_PHY_TEST_DATA_SEL) |=>
        phy_test.test_din == $past(reg_wdata[7:0]) && phy_test.test_addr_sel == $past(reg_wdata[16]))
        else $error("test input or selector not taken from write");
    rdata_idle_a: assert property (clk_en && !(reg_sel && !reg_write) |=> reg_rdata == 32'h0)
        else $error("read data not zero without read");
    reserved_zero_a: assert property (reg_rdata[31:21] == 11'h000)
        else $error("reserved read bits not zero");
    pld_accept_a: assert property (gen_pld_accept == (gen_pld_write && !gen_pld_full))
        else $error("payload accept wrong");
    err_irq_a: assert property (clk_en && ctrl_err != '0 |=> irq)
        else $error("irq missing after error event");
    timeout_read_a: assert property (clk_en && ctrl_err.highspeed_tx_timeout ##1
        rd_of(`OFS_LINK_ERR_STATUS_B) |=> reg_rdata[0]) else $error("timeout flag lost");
    full_write_a: assert property (clk_en && gen_pld_write && gen_pld_full ##1
        rd_of(`OFS_LINK_ERR_STATUS_B) |=> reg_rdata[9]) else $error("full write flag lost");
    ack_read_a: assert property (clk_en && ack_report_valid ##1 rd_of(`OFS_LINK_ERR_STATUS_A) |=>
        (reg_rdata[15:0] & $past(ack_report_bits, 2)) == $past(ack_report_bits, 2))
        else $error("ack report bits lost");
endmodule // link_error_chk
bind link_error_status link_error_chk i_chk (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en),
    .reg_sel(reg_sel), .reg_write(reg_write), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .phy_test(phy_test), .ctrl_err(ctrl_err), .ack_report_valid(ack_report_valid),
    .ack_report_bits(ack_report_bits), .gen_pld_write(gen_pld_write), .gen_pld_full(gen_pld_full),
    .gen_pld_accept(gen_pld_accept), .irq(irq));
`default_nettype wire

// >>> testbench/testbench.sv
// Purpose: self-checking bench for the link error block
// Assumes: reads answer one cycle after they are taken
// Notes:   reset values first, then register rows, then hand-written cases
`include "link_error_defs.svh"
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'b0, rst_n = 1'b0, clk_en = 1'b1, reg_sel = 1'b0, reg_write = 1'b0, irq;
    logic [7:0] reg_addr = 8'h00, dout;
    logic [31:0] reg_wdata = 32'h0, reg_rdata;
    logic ack_report_valid = 1'b0, pld_w = 1'b0, pld_f = 1'b0, cmd_w = 1'b0, cmd_f = 1'b0, pld_a, cmd_a;
    logic [15:0] ack_report_bits = 16'h0000;
    link_error_pkg::phy_state_t phy_state = '0;
    link_error_pkg::lane_err_t lane_err = '0;
    link_error_pkg::ctrl_err_t ctrl_err = '0;
    link_error_pkg::phy_test_t phy_test;
    int fail_count = 0, checks = 0;
    logic [71:0] rows [7] = '{{8'hB4, 32'hFFFF_FFFF, 32'h3}, {8'hB4, 32'h0, 32'h0},
        {8'hC4, 32'hFFFF_FFFF, 32'h001F_FFFF}, {8'hC4, 32'h0, 32'h0}, {8'hB0, 32'hFFFF_FFFF, 32'h35},
        {8'hBC, 32'hFFFF_FFFF, 32'h0}, {8'hFC, 32'hFFFF_FFFF, 32'h0}};
    always #5 sys_clk = ~sys_clk;
    link_error_status i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en), .reg_sel(reg_sel),
        .reg_write(reg_write), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .phy_state(phy_state), .phy_test_dout(dout), .phy_test(phy_test), .lane_err(lane_err),
        .ack_report_valid(ack_report_valid), .ack_report_bits(ack_report_bits), .ctrl_err(ctrl_err),
        .gen_pld_write(pld_w), .gen_pld_full(pld_f), .gen_cmd_write(cmd_w), .gen_cmd_full(cmd_f),
        .gen_pld_accept(pld_a), .gen_cmd_accept(cmd_a), .irq(irq));
    phy_test_model i_phy (.phy_test(phy_test), .phy_test_dout(dout));
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // event strobes drop at the edge that raises the access
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        {ctrl_err, ack_report_valid, pld_w, cmd_w} <= '0;
        reg_sel <= 1'b1; reg_write <= w; reg_addr <= a; reg_wdata <= d;
        @(posedge sys_clk);
        reg_sel <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        acc(1'b0, a, 32'h0);
        chk(reg_rdata, exp);
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (5000) @(posedge sys_clk);
        fail_count++;
        close_out();
    end
    initial begin
        repeat (20) @(posedge sys_clk);
        rst_n <= 1'b1;
        #1 chk(32'(phy_test), 32'h400);
        rd(8'hB4, 32'h1);
        rd(8'hC0, 32'h0);
        $display("reset values done");
        phy_state <= 6'h35;
        for (int i = 0; i < 7; i++) begin
            acc(1'b1, rows[i][71:64], rows[i][63:32]);
            rd(rows[i][71:64], rows[i][31:0]);
        end
        $display("register rows done");
        acc(1'b1, 8'hB8, 32'h0001_00C3);
        acc(1'b1, 8'hB4, 32'h2);
        acc(1'b1, 8'hB4, 32'h0);
        acc(1'b1, 8'hB8, 32'h0000_005A);
        acc(1'b1, 8'hB4, 32'h2);
        repeat (3) @(posedge sys_clk);
        rd(8'hB8, 32'h0000_5A5A);
        acc(1'b1, 8'hB8, 32'h0001_0000);
        repeat (3) @(posedge sys_clk);
        rd(8'hB8, 32'h0001_C300);
        $display("phy test port done");
        @(posedge sys_clk) ctrl_err <= 13'h1FFF;
        rd(8'hC0, 32'h1FFF);
        rd(8'hC0, 32'h0);
        @(posedge sys_clk) {reg_sel, reg_write, reg_addr, ctrl_err} <= {2'b10, 8'hC0, 13'h1};
        rd(8'hC0, 32'h1);
        @(posedge sys_clk) {pld_w, pld_f, cmd_w, cmd_f} <= 4'b1110;
        #1 chk({pld_a, cmd_a}, 32'h1);
        rd(8'hC0, 32'h200);
        $display("status b done");
        @(posedge sys_clk) lane_err <= 5'h1F;
        repeat (4) @(posedge sys_clk);
        #1 chk(irq, 32'h0);
        acc(1'b1, 8'hC4, 32'h0001_0000);
        @(posedge sys_clk) #1 chk(irq, 32'h1);
        @(posedge sys_clk) {ack_report_valid, ack_report_bits} <= {1'b1, 16'hA5C3};
        rd(8'hBC, 32'h001F_A5C3);
        @(posedge sys_clk) #1 chk(irq, 32'h0);
        $display("status a and mask done");
        @(posedge sys_clk) clk_en <= 1'b0;
        acc(1'b1, 8'hB8, 32'h0000_00FF);
        @(posedge sys_clk) clk_en <= 1'b1;
        rd(8'hB8, 32'h0001_C300);
        $display("clock enable freeze done");
        @(posedge sys_clk) rst_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        #1 chk(32'(phy_test), 32'h400);
        rd(8'hC4, 32'h0);
        rd(8'hB0, 32'h35);
        $display("mid-run reset done");
        close_out();
    end
endmodule // testbench
`default_nettype wire
